/* File: ioc_pkg.sv */
// Constants and types for the interrupt and option control register group
package ioc_pkg;

    // Register indexes; byte address is four times the index
    localparam logic [7:0] IDX_INTC = 8'h0B;
    localparam logic [7:0] IDX_INTC_ALT = 8'h8B;
    localparam logic [7:0] IDX_PIR = 8'h0C;
    localparam logic [7:0] IDX_OPT = 8'h81;
    localparam logic [7:0] IDX_PIE = 8'h8C;
    localparam logic [7:0] IDX_RSTC = 8'h8E;
    localparam logic [7:0] IDX_WPU = 8'h95;
    localparam logic [7:0] IDX_IOC = 8'h96;

    // Option register fields
    localparam int OPT_PU_DIS = 7;
    localparam int OPT_EDGE = 6;
    localparam int OPT_CS = 5;
    localparam int OPT_SE = 4;
    localparam int OPT_PS_WDT = 3;

    // Interrupt control fields
    localparam int INT_GLOBAL_EN = 7;
    localparam int INT_PERI_EN = 6;
    localparam int INT_TOVF_EN = 5;
    localparam int INT_PIN_EN = 4;
    localparam int INT_PORT_EN = 3;
    localparam int INT_TOVF_FLAG = 2;
    localparam int INT_PIN_FLAG = 1;
    localparam int INT_PORT_FLAG = 0;

    // Reset-cause fields
    localparam int RSTC_POWERON = 1;
    localparam int RSTC_BROWNOUT = 0;

    // Implemented bit masks
    localparam logic [7:0] PERI_MASK = 8'hC9;
    localparam logic [7:0] RSTC_MASK = 8'h03;
    localparam logic [5:0] WPU_MASK = 6'h37;

    // Reset values
    localparam logic [7:0] OPT_RST = 8'hFF;
    localparam logic [7:0] INTC_RST = 8'h00;
    localparam logic [7:0] PERI_RST = 8'h00;
    localparam logic [7:0] RSTC_RST = 8'h01;
    localparam logic [5:0] WPU_RST = 6'h37;
    localparam logic [5:0] IOC_RST = 6'h00;

    // Prescale ratios at code zero, and the undivided timer ratio
    localparam logic [8:0] TMR_DIV_BASE = 9'h002;
    localparam logic [7:0] WDT_DIV_BASE = 8'h01;
    localparam logic [8:0] TMR_DIV_ONE = 9'h001;

    // Bus constants
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [21:0] ADDR_HI_ZERO = 22'h000000;

    // Bus phase
    typedef enum logic {
        PH_IDLE = 1'b0,
        PH_DATA = 1'b1
    } ioc_phase_e;

endpackage : ioc_pkg

/* File: ioc_top.sv */
// Interrupt, option and reset-cause register group behind an AHB-Lite slave
//
// How it works
// [RL1] Pull-up disable bit set forces all pull-ups off, else per-pin setting.
// [RL2] Edge select picks rising (1) or falling (0) external pin edge.
// [RL3] Clock source bit picks external clock pin (1) or instruction tick (0).
// [RL4] Source edge bit: 1 counts falling, 0 counts rising external edges.
// [RL5] Prescaler goes to the watchdog when assign bit is 1, else to timer.
// [RL6] Rate code gives timer 1:2..1:256 or watchdog 1:1..1:128.
// [RL7] Flags set on their event regardless of the interrupt enable bits; port change still needs a per-pin enable.
// [RL8] Software should clear a flag before enabling its interrupt.
// [RL9] Global enable low blocks every interrupt request.
// [RL10] Peripheral enable low blocks all peripheral interrupts.
// [RL11] Timer rollover sets its flag; it stays until software clears.
// [RL12] Selected external pin edge sets its flag; only software clears.
// [RL13] Change on an enabled port pin sets the port change flag.
// [RL14] Core enables at bits 5..3; port change also needs per-pin enable.
// [RL15] Peripheral enables at bits 7,6,3,0; other bits read zero.
// [RL16] Peripheral flags at bits 7,6,3,0 set by events, cleared by software.
// [RL17] Power-on reset clears the power-on flag; software sets it again.
// [RL18] Brown-out clears the brown-out flag; software sets it again.
// [RL19] Upper six reset-cause bits always read zero.
// [RL20] Interrupt control register appears at two indexes, one storage.
// [RL21] Software assigns prescaler to watchdog for undivided timer rate.
// [RL22] Request needs global enable and an enabled core or peripheral flag.

`timescale 1ns/100ps
`default_nettype none

module ioc_top
    import ioc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Pins and event sources
    input wire logic ext_irq_pin,
    input wire logic ext_timer_clock_pin,
    input wire logic instr_cycle_tick,
    input wire logic [5:0] port_pins,
    input wire logic timer_overflow_pulse,
    input wire logic nv_write_done_pulse,
    input wire logic conversion_done_pulse,
    input wire logic comparator_change_pulse,
    input wire logic timer2nd_overflow_pulse,
    input wire logic brownout_event,
    // Control outputs
    output logic [5:0] pullup_en,
    output logic timer_count_pulse,
    output logic [8:0] timer_div_ratio,
    output logic [7:0] wdt_div_ratio,
    output logic irq_request
);

    ////////////////////////////////////////////////////////////////////
    // State
    ioc_phase_e ph_q, ph_d;
    logic wr_q, wr_d;
    logic [7:0] idx_q, idx_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic hreadyout_q;
    logic [7:0] opt_q, opt_d;
    logic [7:0] intc_q, intc_d;
    logic [7:0] pie_q, pie_d;
    logic [7:0] pir_q, pir_d;
    logic [7:0] rstc_q, rstc_d;
    logic [5:0] wpu_q, wpu_d;
    logic [5:0] ioc_q, ioc_d;
    logic pin_prev_q;
    logic tclk_prev_q;
    logic [5:0] port_prev_q;
    logic smp_valid_q;
    logic [5:0] pullup_q, pullup_d;
    logic tcnt_q, tcnt_d;
    logic [8:0] tdiv_q, tdiv_d;
    logic [7:0] wdiv_q, wdiv_d;
    logic irq_q, irq_d;

    // Decode and event terms
    logic take;
    logic hit;
    logic wr_en;
    logic [7:0] wd;
    logic [7:0] aidx;
    logic ext_edge;
    logic tclk_edge;
    logic port_chg;
    logic [7:0] peri_evt;
    logic core_hit;
    logic peri_hit;

    ////////////////////////////////////////////////////////////////////
    // Event detection on sampled pins
    always_comb begin
        ext_edge = smp_valid_q && (opt_q[OPT_EDGE] ?
            (ext_irq_pin && !pin_prev_q) :
            (!ext_irq_pin && pin_prev_q)); // [RL2]
        tclk_edge = smp_valid_q && (opt_q[OPT_SE] ?
            (!ext_timer_clock_pin && tclk_prev_q) :
            (ext_timer_clock_pin && !tclk_prev_q)); // [RL4]
        port_chg = smp_valid_q &&
            (|((port_pins ^ port_prev_q) & ioc_q)); // [RL13] [RL14]
        peri_evt = {nv_write_done_pulse, conversion_done_pulse, 2'h0,
            comparator_change_pulse, 2'h0, timer2nd_overflow_pulse};
    end

    ////////////////////////////////////////////////////////////////////
    // Bus phase tracking and write strobe
    always_comb begin
        aidx = haddr[9:2];
        take = hsel && hready && (htrans == HTRANS_NONSEQ);
        hit = (haddr[31:10] == ADDR_HI_ZERO);
        ph_d = take ? PH_DATA : PH_IDLE;
        wr_d = take && hwrite && hit;
        idx_d = take ? aidx : idx_q;
        wr_en = (ph_q == PH_DATA) && wr_q;
        wd = hwdata[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Register next values
    always_comb begin
        opt_d = opt_q;
        intc_d = intc_q;
        pie_d = pie_q;
        pir_d = pir_q;
        rstc_d = rstc_q;
        wpu_d = wpu_q;
        ioc_d = ioc_q;
        if (wr_en) begin
            case (idx_q)
                IDX_OPT: begin
                    opt_d = wd;
                end
                IDX_INTC, IDX_INTC_ALT: begin
                    intc_d = wd; // [RL20]
                end
                IDX_PIE: begin
                    pie_d = wd & PERI_MASK; // [RL15]
                end
                IDX_PIR: begin
                    pir_d = wd & PERI_MASK;
                end
                IDX_RSTC: begin
                    rstc_d = wd & RSTC_MASK; // [RL17] [RL18]
                end
                IDX_WPU: begin
                    wpu_d = wd[5:0] & WPU_MASK;
                end
                IDX_IOC: begin
                    ioc_d = wd[5:0];
                end
                default: begin
                    opt_d = opt_q;
                end
            endcase
        end
        // Hardware sets win over a software clear in the same cycle
        intc_d[INT_TOVF_FLAG] = intc_d[INT_TOVF_FLAG] | timer_overflow_pulse; // [RL7] [RL11]
        intc_d[INT_PIN_FLAG] = intc_d[INT_PIN_FLAG] | ext_edge; // [RL12]
        intc_d[INT_PORT_FLAG] = intc_d[INT_PORT_FLAG] | port_chg; // [RL13]
        pir_d = pir_d | (peri_evt & PERI_MASK); // [RL7] [RL16]
        // Brown-out clears its flag over any write
        if (brownout_event) begin
            rstc_d[RSTC_BROWNOUT] = 1'b0; // [RL18]
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Output next values
    always_comb begin
        pullup_d = opt_d[OPT_PU_DIS] ? 6'h00 : wpu_d; // [RL1]
        tcnt_d = opt_q[OPT_CS] ? tclk_edge : instr_cycle_tick; // [RL3]
        tdiv_d = opt_d[OPT_PS_WDT] ? TMR_DIV_ONE :
            (TMR_DIV_BASE << opt_d[2:0]); // [RL5] [RL6]
        wdiv_d = opt_d[OPT_PS_WDT] ? (WDT_DIV_BASE << opt_d[2:0]) :
            WDT_DIV_BASE; // [RL5] [RL6]
        core_hit = |(intc_d[INT_TOVF_EN:INT_PORT_EN] &
            intc_d[INT_TOVF_FLAG:INT_PORT_FLAG]); // [RL14]
        peri_hit = intc_d[INT_PERI_EN] && (|(pie_d & pir_d)); // [RL10]
        irq_d = intc_d[INT_GLOBAL_EN] && (core_hit || peri_hit); // [RL9] [RL22]
    end

    ////////////////////////////////////////////////////////////////////
    // Read data, taken from next values so a write just done is seen
    always_comb begin
        hrdata_d = 32'h00000000;
        if (take && !hwrite && hit) begin
            case (aidx)
                IDX_OPT: begin
                    hrdata_d[7:0] = opt_d;
                end
                IDX_INTC, IDX_INTC_ALT: begin
                    hrdata_d[7:0] = intc_d; // [RL20]
                end
                IDX_PIE: begin
                    hrdata_d[7:0] = pie_d;
                end
                IDX_PIR: begin
                    hrdata_d[7:0] = pir_d;
                end
                IDX_RSTC: begin
                    hrdata_d[7:0] = rstc_d & RSTC_MASK; // [RL19]
                end
                IDX_WPU: begin
                    hrdata_d[5:0] = wpu_d;
                end
                IDX_IOC: begin
                    hrdata_d[5:0] = ioc_d;
                end
                default: begin
                    hrdata_d = 32'h00000000;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Registers; asynchronous reset counts as power-on reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_q <= PH_IDLE;
            wr_q <= 1'b0;
            idx_q <= 8'h00;
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            opt_q <= OPT_RST;
            intc_q <= INTC_RST;
            pie_q <= PERI_RST;
            pir_q <= PERI_RST;
            rstc_q <= RSTC_RST; // [RL17]
            wpu_q <= WPU_RST;
            ioc_q <= IOC_RST;
            pin_prev_q <= 1'b0;
            tclk_prev_q <= 1'b0;
            port_prev_q <= 6'h00;
            smp_valid_q <= 1'b0;
            pullup_q <= 6'h00;
            tcnt_q <= 1'b0;
            tdiv_q <= TMR_DIV_ONE;
            wdiv_q <= WDT_DIV_BASE;
            irq_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            wr_q <= wr_d;
            idx_q <= idx_d;
            hrdata_q <= hrdata_d;
            hreadyout_q <= 1'b1;
            opt_q <= opt_d;
            intc_q <= intc_d;
            pie_q <= pie_d;
            pir_q <= pir_d;
            rstc_q <= rstc_d;
            wpu_q <= wpu_d;
            ioc_q <= ioc_d;
            pin_prev_q <= ext_irq_pin;
            tclk_prev_q <= ext_timer_clock_pin;
            port_prev_q <= port_pins;
            smp_valid_q <= 1'b1;
            pullup_q <= pullup_d;
            tcnt_q <= tcnt_d;
            tdiv_q <= tdiv_d;
            wdiv_q <= wdiv_d;
            irq_q <= irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Port drive
    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign pullup_en = pullup_q;
    assign timer_count_pulse = tcnt_q;
    assign timer_div_ratio = tdiv_q;
    assign wdt_div_ratio = wdiv_q;
    assign irq_request = irq_q;

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    pullup_gate_a: assert property ( // [RL1]
        pullup_en == (opt_q[OPT_PU_DIS] ? 6'h00 : wpu_q))
        else $error("pull-up enables disagree with option and per-pin bits");

    ext_edge_a: assert property ( // [RL2]
        (smp_valid_q && opt_q[OPT_EDGE] && ext_irq_pin && !pin_prev_q)
        |=> intc_q[INT_PIN_FLAG])
        else $error("rising external edge did not set its flag");

    clk_source_a: assert property ( // [RL3]
        (!opt_q[OPT_CS] && instr_cycle_tick) |=> timer_count_pulse)
        else $error("instruction tick not passed to timer");

    ext_count_a: assert property ( // [RL4]
        (opt_q[OPT_CS] && !opt_q[OPT_SE] && smp_valid_q
         && $rose(ext_timer_clock_pin)) |=> timer_count_pulse)
        else $error("rising timer clock edge not counted");

    // Ratios lag reset by one edge, so the check starts once sampling is armed
    prescale_route_a: assert property ( // [RL6]
        smp_valid_q |->
        (opt_q[OPT_PS_WDT] ? (timer_div_ratio == TMR_DIV_ONE) &&
            (wdt_div_ratio == (WDT_DIV_BASE << opt_q[2:0])) :
            (timer_div_ratio == (TMR_DIV_BASE << opt_q[2:0])) &&
            (wdt_div_ratio == WDT_DIV_BASE)))
        else $error("prescale ratios wrong for assignment");

    flag_sticky_a: assert property ( // [RL11]
        timer_overflow_pulse |=> intc_q[INT_TOVF_FLAG] [*1] ##1
        (intc_q[INT_TOVF_FLAG] || $past(wr_en)))
        else $error("timer overflow flag not set or lost");

    global_block_a: assert property ( // [RL9]
        !intc_q[INT_GLOBAL_EN] |-> !irq_request)
        else $error("request while global enable is low");

    peri_block_a: assert property ( // [RL10]
        (!intc_q[INT_PERI_EN] &&
         !(|(intc_q[INT_TOVF_EN:INT_PORT_EN] & intc_q[INT_TOVF_FLAG:INT_PORT_FLAG])))
        |-> !irq_request)
        else $error("peripheral request passed with peripheral enable low");

    port_change_a: assert property ( // [RL13]
        port_chg |=> intc_q[INT_PORT_FLAG])
        else $error("port change did not set its flag");

    peri_flags_a: assert property ( // [RL16]
        (|peri_evt) |=> ((pir_q & $past(peri_evt)) == $past(peri_evt)))
        else $error("peripheral event did not set its flag");

    enable_unused_a: assert property ( // [RL15]
        (pie_q & ~PERI_MASK) == 8'h00)
        else $error("unimplemented enable bit is set");

    brownout_clear_a: assert property ( // [RL18]
        brownout_event |=> !rstc_q[RSTC_BROWNOUT])
        else $error("brown-out did not clear its flag");

    rstc_upper_a: assert property ( // [RL19]
        (ph_q == PH_DATA && !wr_q && idx_q == IDX_RSTC)
        |-> hrdata[7:2] == 6'h00)
        else $error("reset-cause upper bits read nonzero");

    request_on_a: assert property ( // [RL22]
        (intc_q[INT_GLOBAL_EN] && intc_q[INT_TOVF_EN] && intc_q[INT_TOVF_FLAG])
        |-> irq_request)
        else $error("enabled timer flag raised no request");

    irq_raised_c: cover property (
        !irq_request ##1 irq_request);
    peri_path_c: cover property (
        intc_q[INT_PERI_EN] && irq_request && !core_hit);
    alias_write_c: cover property (
        wr_en && idx_q == IDX_INTC_ALT);
    set_over_clear_c: cover property (
        wr_en && idx_q == IDX_INTC && timer_overflow_pulse);

endmodule : ioc_top

`default_nettype wire

/* File: ioc_evt_src.sv */
// Behavioural model of the peripheral event sources beside the register group
`timescale 1ns/100ps
`default_nettype none

module ioc_evt_src (
    // Clock and command from the bench
    input wire logic hclk,
    input wire logic [5:0] fire,
    // One-cycle event pulses
    output logic timer_overflow_pulse,
    output logic nv_write_done_pulse,
    output logic conversion_done_pulse,
    output logic comparator_change_pulse,
    output logic timer2nd_overflow_pulse,
    output logic brownout_event
);

    // Each commanded event leaves as a pulse one cycle long
    always @(posedge hclk) begin
        {brownout_event, timer2nd_overflow_pulse, comparator_change_pulse,
            conversion_done_pulse, nv_write_done_pulse, timer_overflow_pulse} <= fire;
    end

endmodule : ioc_evt_src

`default_nettype wire

/* File: ioc_top_tb.sv */
// Self-checking testbench for the interrupt and option register group
`timescale 1ns/100ps
`default_nettype none

module ioc_top_tb
    import ioc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_ph;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic ext_pin, ext_clk, tick, tcp, irq;
    logic t0_ovf, nv_done, cv_done, cmp_chg, t2_ovf, bo_evt;
    logic [5:0] port_pins, fire, pullup_en;
    logic [8:0] tdiv;
    logic [7:0] wdiv, r;
    logic [31:0] exp_q[$];
    int n_mismatch, checks, n_pulse;

    assign hready = hreadyout;

    // Clock
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    ioc_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin(ext_pin),
        .ext_timer_clock_pin(ext_clk), .instr_cycle_tick(tick), .port_pins(port_pins),
        .timer_overflow_pulse(t0_ovf), .nv_write_done_pulse(nv_done),
        .conversion_done_pulse(cv_done), .comparator_change_pulse(cmp_chg),
        .timer2nd_overflow_pulse(t2_ovf), .brownout_event(bo_evt), .pullup_en(pullup_en),
        .timer_count_pulse(tcp), .timer_div_ratio(tdiv), .wdt_div_ratio(wdiv),
        .irq_request(irq));

    ioc_evt_src src_u (.hclk(hclk), .fire(fire), .timer_overflow_pulse(t0_ovf),
        .nv_write_done_pulse(nv_done), .conversion_done_pulse(cv_done),
        .comparator_change_pulse(cmp_chg), .timer2nd_overflow_pulse(t2_ovf),
        .brownout_event(bo_evt));

    ////////////////////////////////////////////////////////////////////////////
    // Read data watcher takes the oldest expected value
    always @(posedge hclk) begin
        if (rd_ph && hready === 1'b1) begin
            checks++;
            if (hrdata !== exp_q.pop_front()) begin
                n_mismatch++;
                $display("Error at %0t: read data %0h wrong", $time, hrdata);
            end
        end
    end

    // Timer count pulse counter
    always @(posedge hclk) begin
        if (tcp === 1'b1) begin
            n_pulse++;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] ba(input logic [7:0] idx);
        return {ADDR_HI_ZERO, idx, 2'h0};
    endfunction : ba

    // One single transfer, address then data phase
    task automatic bus(input logic [31:0] a, input logic w, input logic [7:0] d);
        @(posedge hclk);
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        rd_ph <= !w;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_ph <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(ba(idx), 1'b1, d);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(a, 1'b0, 8'h00);
    endtask : rd

    task automatic st;
        repeat (3) @(posedge hclk);
        #1;
    endtask : st

    task automatic cmp(input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            n_mismatch++;
            $display("Error at %0t: output %0h expected %0h", $time, got, e);
        end
    endtask : cmp

    task automatic ev(input logic [5:0] m);
        @(posedge hclk);
        fire <= m;
        @(posedge hclk);
        fire <= 6'h00;
        st();
    endtask : ev

    // Timer clock source case: option, external clock level, tick, pulses
    task automatic tc(input logic [7:0] opt, input logic lvl, input logic tk, input int e);
        n_pulse = 0;
        wr(IDX_OPT, opt);
        ext_clk <= lvl;
        tick <= tk;
        @(posedge hclk);
        tick <= 1'b0;
        st();
        cmp(32'(n_pulse), 32'(e));
    endtask : tc

    // External pin case: option, new pin level, expected control value
    task automatic px(input logic [7:0] opt, input logic lvl, input logic [7:0] e);
        wr(IDX_OPT, opt);
        wr(IDX_INTC, 8'h00);
        ext_pin <= lvl;
        st();
        rd(ba(IDX_INTC), e);
    endtask : px

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog against a hang
    initial begin
        #100000;
        n_mismatch++;
        $display("Error at %0t: timeout", $time);
        report_and_stop();
    end

    // Main sequence
    initial begin
        {hresetn, hwrite, rd_ph, ext_pin, ext_clk, tick} = 6'h00;
        {haddr, hwdata, htrans, hsize, port_pins, fire} = '0;
        hsel = 1'b1;
        n_mismatch = 0;
        checks = 0;
        n_pulse = 0;
        void'($urandom(26));
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        st();
        cmp(32'(pullup_en), 32'h0);
        cmp(32'(wdiv), 32'h80);
        cmp(32'(tdiv), 32'h1);
        cmp(32'(hresp), 32'h0);
        cmp(32'(hreadyout), 32'h1);
        rd(ba(IDX_OPT), OPT_RST);
        rd(ba(IDX_INTC), INTC_RST);
        rd(ba(IDX_PIE), PERI_RST);
        rd(ba(IDX_PIR), PERI_RST);
        rd(ba(IDX_RSTC), RSTC_RST);
        $display("test reset done");
        for (int c = 0; c < 8; c++) begin
            wr(IDX_OPT, {5'h10, c[2:0]});
            st();
            cmp(32'(tdiv), 32'h2 << c);
            wr(IDX_OPT, {5'h11, c[2:0]});
            st();
            cmp(32'(wdiv), 32'h1 << c);
            cmp(32'(tdiv), 32'h1);
        end
        wr(IDX_OPT, 8'h08);
        st();
        cmp(32'(pullup_en), 32'(WPU_RST));
        r = 8'($urandom);
        wr(IDX_WPU, r);
        st();
        cmp(32'(pullup_en), 32'(r[5:0] & WPU_MASK));
        rd(ba(IDX_WPU), {2'h0, r[5:0] & WPU_MASK});
        $display("test option done");
        tc(8'h88, 1'b1, 1'b1, 1);
        tc(8'hA8, 1'b0, 1'b1, 0);
        tc(8'hA8, 1'b1, 1'b0, 1);
        tc(8'hB8, 1'b0, 1'b0, 1);
        tc(8'hB8, 1'b1, 1'b0, 0);
        $display("test timer source done");
        ev(6'h1E);
        rd(ba(IDX_PIR), PERI_MASK);
        ev(6'h01);
        rd(ba(IDX_INTC), 8'h04);
        r = 8'($urandom);
        wr(IDX_PIE, r);
        rd(ba(IDX_PIE), r & PERI_MASK);
        wr(IDX_PIR, 8'h00);
        rd(ba(IDX_PIR), 8'h00);
        wr(IDX_INTC, 8'h00);
        rd(ba(IDX_INTC), 8'h00);
        wr(IDX_PIE, 8'h01);
        ev(6'h10);
        cmp(32'(irq), 32'h0);
        wr(IDX_INTC, 8'h40);
        st();
        cmp(32'(irq), 32'h0);
        wr(IDX_INTC, 8'h80);
        st();
        cmp(32'(irq), 32'h0);
        wr(IDX_INTC, 8'hC0);
        st();
        cmp(32'(irq), 32'h1);
        wr(IDX_PIR, 8'h00);
        wr(IDX_INTC, 8'hA0);
        st();
        cmp(32'(irq), 32'h0);
        ev(6'h01);
        cmp(32'(irq), 32'h1);
        $display("test events done");
        px(8'hC8, 1'b1, 8'h02);
        px(8'hC8, 1'b0, 8'h00);
        px(8'h88, 1'b1, 8'h00);
        px(8'h88, 1'b0, 8'h02);
        rd(ba(IDX_INTC), 8'h02);
        wr(IDX_INTC, 8'h00);
        wr(IDX_IOC, 8'h3F);
        rd(ba(IDX_IOC), 8'h3F);
        port_pins <= 6'h20;
        st();
        rd(ba(IDX_INTC), 8'h01);
        wr(IDX_IOC, 8'h00);
        wr(IDX_INTC, 8'h00);
        port_pins <= 6'h00;
        st();
        rd(ba(IDX_INTC), 8'h00);
        $display("test pins done");
        r = 8'($urandom);
        wr(IDX_INTC, r);
        rd(ba(IDX_INTC_ALT), r);
        wr(IDX_INTC_ALT, 8'h00);
        rd(ba(IDX_INTC), 8'h00);
        ev(6'h20);
        rd(ba(IDX_RSTC), 8'h00);
        wr(IDX_RSTC, 8'hFF);
        rd(ba(IDX_RSTC), RSTC_MASK);
        rd(32'h0000_03FC, 8'h00);
        rd(32'h0000_042C, 8'h00);
        $display("test map done");
        report_and_stop();
    end

endmodule : ioc_top_tb

`default_nettype wire
